//--- bench/acs_host.sv
// host model: bus master that reads one frame over the link
`timescale 1ns/10ps
module acs_host (
  input wire logic line,
  output logic link_sclk,
  output logic link_cs_n
);
  // sole device on the bus, so only one chip select ever exists; it is pulsed for every frame,
  // never tied low, so the crc and no-skip duties of a tied-low select do not arise here
  // the link side has no reset of its own: give it one clean rising edge of chip select
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b0;
    #1 link_cs_n = 1'b1;
  end

  // clock stands still outside frames; 12 ns period inside
  task automatic read_frame(output logic [71:0] frame);
    link_cs_n = 1'b0;
    #400;
    for (int i = 71; i >= 0; i--) begin
      #6 link_sclk = 1'b1;
      #6 link_sclk = 1'b0;
      frame[i] = line;
    end
    #6 link_cs_n = 1'b1;
  endtask : read_frame
endmodule : acs_host

//--- bench/adc_calibration_and_multi_device_sync_bench.sv
// self-checking bench for the calibration and sync block
`timescale 1ns/10ps
module adc_calibration_and_multi_device_sync_bench import acs_pkg::*;;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  logic core_clk = 1'b0, reset = 1'b1, conv_strobe = 1'b0, align_reset_n = 1'b1, idle_pat = 1'b0;
  logic [ACS_CH-1:0][ACS_DW-1:0] raw_data = '0, expd = '0;
  logic [ACS_CH-1:0][15:0] offset_cal_upper = '0, offset_cal_lower = '0, gain_cal_upper = '0, gain_cal_lower = '0;
  logic [ACS_CH-1:0][ACS_PW-1:0] channel_phase_shift = '0;
  wire link_sclk, link_cs_n, link_dout, link_dout_oe, conversion_ready_pin_n, line;
  wire [ACS_CH-1:0][15:0] gain_cal_lower_rd;
  wire [ACS_CH-1:0][ACS_DW-1:0] corrected_data;
  int bad_count = 0, checks_done = 0, cycles = 0;

  // a released line carries a changing pattern, never the last bit
  assign line = link_dout_oe ? link_dout : idle_pat;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    idle_pat <= ~idle_pat;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end

  acs_top i_acs_top (.core_clk(core_clk), .reset(reset), .conv_strobe(conv_strobe), .raw_data(raw_data),
    .offset_cal_upper(offset_cal_upper), .offset_cal_lower(offset_cal_lower), .gain_cal_upper(gain_cal_upper),
    .gain_cal_lower(gain_cal_lower), .channel_phase_shift(channel_phase_shift), .align_reset_n(align_reset_n),
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_dout(link_dout), .link_dout_oe(link_dout_oe),
    .conversion_ready_pin_n(conversion_ready_pin_n), .gain_cal_lower_rd(gain_cal_lower_rd),
    .corrected_data(corrected_data));
  acs_host i_acs_host (.line(line), .link_sclk(link_sclk), .link_cs_n(link_cs_n));

  // ----------------------------------------------------------------
  // reference arithmetic
  // ----------------------------------------------------------------
  function automatic logic signed [23:0] sat(input longint v);
    return (v > 64'sh7fffff) ? 24'sh7fffff : (v < -64'sh800000) ? 24'sh800000 : v[23:0];
  endfunction : sat

  function automatic logic [23:0] expect_val(input logic [23:0] raw, input logic [23:0] off, input logic [23:0] g);
    longint d;
    d = sat(longint'($signed(raw)) - longint'($signed(off)));
    return sat((d * longint'({40'h0, g})) >>> 23);
  endfunction : expect_val

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic load(input int k, input logic [23:0] raw, input logic [23:0] off, input logic [23:0] g,
                      input logic [7:0] ph);
    raw_data[k] = raw;
    offset_cal_upper[k] = off[23:8];
    offset_cal_lower[k] = {off[7:0], 8'h5a};
    gain_cal_upper[k] = g[23:8];
    gain_cal_lower[k] = {g[7:0], 8'ha5};
    channel_phase_shift[k] = ph;
    expd[k] = expect_val(raw, off, g);
  endtask : load

  // strobe once and note the first cycle at which each channel shows its value
  task automatic convert(input bit abort);
    int seen [ACS_CH];
    @(negedge core_clk) conv_strobe = 1'b1;
    for (int n = 1; n < 40; n++) begin
      @(negedge core_clk);
      conv_strobe = 1'b0;
      if (abort && n == 2) align_reset_n = 1'b0;
      for (int k = 0; k < ACS_CH; k++) if (seen[k] == 0 && corrected_data[k] === expd[k]) seen[k] = n;
    end
    if (abort) begin
      `CHK("aborted ch2", 0, seen[2])
      `CHK("zero gain", expd[0], corrected_data[0])
      `CHK("aborted ready", 1'b1, conversion_ready_pin_n)
      align_reset_n = 1'b1;
      repeat (4) @(negedge core_clk);
    end else begin
      for (int k = 0; k < ACS_CH; k++) begin
        `CHK("capture cycle", 2 + (k > 0 ? int'(channel_phase_shift[k]) : 0), seen[k])
        `CHK("corrected", expd[k], corrected_data[k])
        `CHK("gain low", {gain_cal_lower[k][15:8], 8'h00}, gain_cal_lower_rd[k])
      end
      `CHK("ready", 1'b0, conversion_ready_pin_n)
    end
  endtask : convert

  task automatic read_check;
    logic [71:0] fr;
    i_acs_host.read_frame(fr);
    `CHK("frame", {expd[2], expd[1], expd[0]}, fr)
    @(negedge core_clk);
    `CHK("released", 1'b0, link_dout_oe)
    repeat (4) @(negedge core_clk);
    `CHK("ready idle", 1'b1, conversion_ready_pin_n)
  endtask : read_check

  task automatic conclude;
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("reset data", '0, corrected_data)
    `CHK("reset ready", 1'b1, conversion_ready_pin_n)
    `CHK("reset rd", '0, gain_cal_lower_rd)
    `CHK("reset oe", 1'b0, link_dout_oe)
    load(0, 24'h100000, 24'h000000, 24'h800000, 8'h07);
    load(1, 24'hf00000, 24'hfff000, 24'h400000, 8'h04);
    load(2, 24'h012345, 24'h000045, 24'hc00000, 8'h09);
    convert(1'b0);
    read_check();
    // overflow in both subtraction and product must clamp
    load(0, 24'h7fffff, 24'hff0000, 24'h800000, 8'h03);
    load(1, 24'h800000, 24'h010000, 24'h800000, 8'h00);
    load(2, 24'h600000, 24'h000000, 24'hffffff, 8'h01);
    convert(1'b0);
    read_check();
    load(0, 24'h000001, 24'h000000, 24'h000000, 8'h00);
    load(1, 24'h000777, 24'h000000, 24'h800000, 8'h14);
    load(2, 24'h000555, 24'h000000, 24'h800000, 8'h14);
    convert(1'b1);
    conclude();
  end
endmodule : adc_calibration_and_multi_device_sync_bench

//--- src/acs_pkg.sv
// constants, types and correction functions for the calibration and sync block
package acs_pkg;
  localparam int ACS_CH = 3;
  localparam int ACS_DW = 24;
  localparam int ACS_PW = 8;
  localparam int ACS_FRAME_BITS = ACS_CH * ACS_DW;
  localparam int ACS_GAIN_FRAC = 23;
  localparam int ACS_LO_BYTE = 8;
  localparam logic [23:0] ACS_GAIN_UNITY = 24'h800000;
  localparam logic signed [23:0] ACS_POS_MAX = 24'sh7fffff;
  localparam logic signed [23:0] ACS_NEG_MIN = 24'sh800000;
  localparam logic ACS_READY_IDLE = 1'b1;
  localparam logic [6:0] ACS_BITS_END = 7'h48;

  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_WAIT = 3'b010,
    ACS_PUBLISH = 3'b100
  } acs_state_t;

  // -----------------------------------------------------------------
  // correction arithmetic
  // -----------------------------------------------------------------
  function automatic logic signed [23:0] acs_sat(input logic signed [49:0] v);
    if (v > ACS_POS_MAX) begin
      return ACS_POS_MAX;
    end else if (v < ACS_NEG_MIN) begin
      return ACS_NEG_MIN;
    end
    return v[23:0];
  endfunction : acs_sat

  // upper word holds bits 23..8, lower word's high byte bits 7..0
  function automatic logic [23:0] acs_join(input logic [15:0] upper, input logic [15:0] lower);
    return {upper, lower[15:ACS_LO_BYTE]};
  endfunction : acs_join

  function automatic logic signed [23:0] acs_correct(input logic signed [23:0] raw,
                                                     input logic signed [23:0] off,
                                                     input logic [23:0] gain);
    logic signed [49:0] d;
    logic signed [49:0] p;
    d = 50'(raw) - 50'(off);
    d = 50'(acs_sat(d));
    p = d * $signed({26'h0, gain});
    return acs_sat(p >>> ACS_GAIN_FRAC);
  endfunction : acs_correct
endpackage : acs_pkg

//--- src/acs_top.sv
// calibration, phase alignment and serial read-out of corrected samples
`timescale 1ns/10ps
module acs_top
  import acs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic conv_strobe,
  input wire logic [ACS_CH-1:0][ACS_DW-1:0] raw_data,
  input wire logic [ACS_CH-1:0][15:0] offset_cal_upper,
  input wire logic [ACS_CH-1:0][15:0] offset_cal_lower,
  input wire logic [ACS_CH-1:0][15:0] gain_cal_upper,
  input wire logic [ACS_CH-1:0][15:0] gain_cal_lower,
  input wire logic [ACS_CH-1:0][ACS_PW-1:0] channel_phase_shift,
  input wire logic align_reset_n,
  input wire logic link_sclk,
  input wire logic link_cs_n,
  output logic link_dout,
  output logic link_dout_oe,
  output logic conversion_ready_pin_n,
  output logic [ACS_CH-1:0][15:0] gain_cal_lower_rd,
  output logic [ACS_CH-1:0][ACS_DW-1:0] corrected_data
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic cs_meta_reg, cs_sync_reg, align_meta_reg, align_sync_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      align_meta_reg <= 1'b1;
      align_sync_reg <= 1'b1;
    end else begin
      cs_meta_reg <= link_cs_n;
      cs_sync_reg <= cs_meta_reg;
      align_meta_reg <= align_reset_n;
      align_sync_reg <= align_meta_reg;
    end
  end

  // -----------------------------------------------------------------
  // sample capture and correction
  // -----------------------------------------------------------------
  acs_state_t state_reg, state_next;
  logic [ACS_CH-1:0][ACS_PW-1:0] cnt_reg, cnt_next;
  logic [ACS_CH-1:0] cap_reg, cap_next;
  logic [ACS_CH-1:0][ACS_DW-1:0] corr_reg, corr_next;
  logic [ACS_CH-1:0][ACS_DW-1:0] hold_reg, hold_next;
  logic ready_n_reg, ready_n_next;
  logic [ACS_CH-1:0][15:0] glo_reg, glo_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cap_next = cap_reg;
    corr_next = corr_reg;
    hold_next = hold_reg;
    ready_n_next = ready_n_reg;
    for (int ch = 0; ch < ACS_CH; ch++) begin
      glo_next[ch] = {gain_cal_lower[ch][15:ACS_LO_BYTE], 8'h00};
    end
    unique case (state_reg)
      ACS_IDLE: begin
        if (conv_strobe) begin
          cnt_next = channel_phase_shift;
          cap_next = '0;
          state_next = ACS_WAIT;
        end
      end
      ACS_WAIT: begin
        for (int ch = 0; ch < ACS_CH; ch++) begin
          if (!cap_reg[ch]) begin
            // channel 0 is the zero-phase reference, so its setting is ignored
            if (ch == 0 || cnt_reg[ch] == '0) begin
              corr_next[ch] = acs_correct(raw_data[ch], acs_join(offset_cal_upper[ch], offset_cal_lower[ch]),
                                          acs_join(gain_cal_upper[ch], gain_cal_lower[ch]));
              cap_next[ch] = 1'b1;
            end else begin
              cnt_next[ch] = cnt_reg[ch] - 8'h01;
            end
          end
        end
        if (&cap_reg) begin
          state_next = ACS_PUBLISH;
        end
      end
      ACS_PUBLISH: begin
        // the read-out copy only changes between frames, so the link side sees it still
        if (cs_sync_reg) begin
          hold_next = corr_reg;
          ready_n_next = 1'b0;
          state_next = ACS_IDLE;
        end
      end
    endcase
    if (!cs_sync_reg) begin
      ready_n_next = ACS_READY_IDLE;
    end
    if (!align_sync_reg) begin
      state_next = ACS_IDLE;
      cap_next = '0;
      ready_n_next = ACS_READY_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ACS_IDLE;
      cnt_reg <= '0;
      cap_reg <= '0;
      corr_reg <= '0;
      hold_reg <= '0;
      ready_n_reg <= ACS_READY_IDLE;
      glo_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cap_reg <= cap_next;
      corr_reg <= corr_next;
      hold_reg <= hold_next;
      ready_n_reg <= ready_n_next;
      glo_reg <= glo_next;
    end
  end

  assign conversion_ready_pin_n = ready_n_reg;
  assign corrected_data = corr_reg;
  assign gain_cal_lower_rd = glo_reg;

  // -----------------------------------------------------------------
  // serial read-out on the link clock
  // -----------------------------------------------------------------
  logic [6:0] bit_cnt_reg, bit_cnt_next;
  logic [ACS_FRAME_BITS-1:0] shift_reg, shift_next;
  logic dout_reg, dout_next, oe_reg, oe_next;

  always_comb begin
    oe_next = 1'b1;
    bit_cnt_next = bit_cnt_reg;
    if (bit_cnt_reg != ACS_BITS_END) begin
      bit_cnt_next = bit_cnt_reg + 7'h01;
    end
    if (bit_cnt_reg == '0) begin
      {dout_next, shift_next} = {hold_reg, 1'b0};
    end else begin
      {dout_next, shift_next} = {shift_reg, 1'b0};
    end
  end

  // chip select high clears the driver at once, even with the link clock stopped
  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  assign link_dout = dout_reg;
  assign link_dout_oe = oe_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence wait_entry_s;
    state_reg == ACS_IDLE && conv_strobe && align_sync_reg;
  endsequence

  output_release_a: assert property (cs_sync_reg && $past(cs_sync_reg) |-> !link_dout_oe)
    else $error("data output driven while chip select high");
  offset_sub_a: assert property (state_reg == ACS_WAIT && !cap_reg[0] && align_sync_reg &&
                                 acs_join(gain_cal_upper[0], gain_cal_lower[0]) == ACS_GAIN_UNITY
                                 |=> corr_reg[0] == acs_sat(50'($signed($past(raw_data[0]))) - 50'($signed(
                                     acs_join($past(offset_cal_upper[0]), $past(offset_cal_lower[0]))))))
    else $error("offset not subtracted at unity gain");
  gain_zero_a: assert property (state_reg == ACS_WAIT && !cap_reg[0] && align_sync_reg &&
                                acs_join(gain_cal_upper[0], gain_cal_lower[0]) == '0 |=> corr_reg[0] == '0)
    else $error("zero gain did not give zero");
  gain_unity_a: assert property (state_reg == ACS_WAIT && !cap_reg[0] && align_sync_reg &&
                                 acs_join(offset_cal_upper[0], offset_cal_lower[0]) == '0 &&
                                 acs_join(gain_cal_upper[0], gain_cal_lower[0]) == ACS_GAIN_UNITY
                                 |=> corr_reg[0] == $past(raw_data[0]))
    else $error("midpoint gain is not unity");
  sat_high_a: assert property (state_reg == ACS_WAIT && !cap_reg[0] && align_sync_reg &&
                               raw_data[0] == ACS_POS_MAX && offset_cal_upper[0][15] &&
                               gain_cal_upper[0][15] |=> corr_reg[0] == ACS_POS_MAX)
    else $error("overflow wrapped instead of saturating");
  ref_first_a: assert property (wait_entry_s ##1 state_reg == ACS_WAIT |=> cap_reg[0])
    else $error("reference channel not captured first");
  phase_hold_a: assert property (state_reg == ACS_WAIT && !cap_reg[2] && cnt_reg[2] != '0 && align_sync_reg
                                 |=> !cap_reg[2] && cnt_reg[2] == $past(cnt_reg[2]) - 8'h01)
    else $error("channel captured before its phase delay");
  low_byte_a: assert property (##1 gain_cal_lower_rd[2][7:0] == 8'h00 &&
                               gain_cal_lower_rd[2][15:8] == $past(gain_cal_lower[2][15:8]))
    else $error("gain lower word readback wrong");

endmodule : acs_top
